// File: motor_pwm_pkg.sv
// Purpose: Shared constants for the three-phase motor PWM block
// Assumes: 16-bit register port, 4-bit word address
// Notes:   Phase index 0 is U, 1 is V, 2 is W
package motor_pwm_pkg;
   localparam int AW = 4;
   localparam int DW = 16;
   localparam int NPH = 3;
   localparam int DTW = 8;
   localparam int ICW = 4;
   localparam int NIRQ = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Register word addresses
   localparam logic [AW-1:0] A_CTRL0    = 4'h0; // motor_ctrl_reg0
   localparam logic [AW-1:0] A_CTRL1    = 4'h1; // motor_ctrl_reg1
   localparam logic [AW-1:0] A_PERIOD   = 4'h2; // carrier_period_reg
   localparam logic [AW-1:0] A_DTT      = 4'h3; // dead_time_value_reg
   localparam logic [AW-1:0] A_ICNT     = 4'h4; // carrier_irq_count_reg
   localparam logic [AW-1:0] A_DUTY0    = 4'h5; // u, v, w duty at +0..+2
   localparam logic [AW-1:0] A_ALT0     = 4'h8; // u, v, w alternate duty
   localparam logic [AW-1:0] A_CNT      = 4'hb; // carrier counter, read only
   localparam logic [AW-1:0] A_IRQ_STAT = 4'hc;
   localparam logic [AW-1:0] A_IRQ_EN   = 4'hd;
   localparam logic [AW-1:0] A_IRQ_CLR  = 4'he;
   localparam logic [AW-1:0] A_STATUS   = 4'hf;

   ////////////////////////////////////////////////////////////////////////////
   // Bit positions
   localparam int B_ICNT_EN = 0;
   localparam int B_USE     = 2;
   localparam int B_OEN     = 3;
   localparam int B_GUARD   = 4;
   localparam int B_MOD     = 6;
   localparam int B_XFER    = 7;
   localparam int B_MODE1   = 0;
   localparam int B_DT_DIS  = 1;
   localparam int B_CW_SEL  = 2;
   localparam int B_CHG_IMM = 3;
   localparam int B_NMI_EN  = 4;
   localparam int I_CARRIER = 0;
   localparam int I_GUARD   = 1;
   localparam int I_NMI     = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [DW-1:0]  PERIOD_RST = 16'h00ff;
   localparam logic [DTW-1:0] DTT_RST    = 8'h00;
   localparam logic [ICW-1:0] ICNT_RST   = 4'h1;
   localparam logic [ICW-1:0] ICNT_START = 4'h1;
endpackage : motor_pwm_pkg

// File: pwm_phase.sv
// Purpose: One phase: one-shot duty timer, dead time, complementary pair
// Assumes: trig_in is a one-cycle pulse on carrier underflow
// Notes:   Turn-off is immediate, only turn-on waits for the dead time
`timescale 1ns/1ps
`default_nettype none
module pwm_phase (
   input  wire logic                            clk_in,    // Clock
   input  wire logic                            rst_n_in,  // Sync reset
   input  wire logic                            trig_in,   // Fire one-shot
   input  wire logic [motor_pwm_pkg::DW-1:0]    load_in,   // Pulse length
   input  wire logic                            inv_in,    // Triangular half
   input  wire logic                            dt_dis_in, // No dead time
   input  wire logic [motor_pwm_pkg::DTW-1:0]   dtt_in,    // Dead time
   output logic                                 pulse_out, // One-shot level
   output logic                                 hi_out,    // High side on
   output logic                                 lo_out     // Low side on
);
   logic [motor_pwm_pkg::DW-1:0]  shot_r;
   logic [motor_pwm_pkg::DTW-1:0] dead_r;
   logic                          lvl_r;
   logic                          lvl;
   logic                          settled;

   assign lvl     = (shot_r != '0) ^ inv_in;
   assign settled = dt_dis_in || (dead_r == '0 && lvl == lvl_r);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         shot_r <= '0;
      end else if (trig_in) begin
         shot_r <= load_in;
      end else if (shot_r != '0) begin
         shot_r <= shot_r - 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         lvl_r  <= 1'b0;
         dead_r <= '0;
      end else begin
         lvl_r <= lvl;
         if (lvl != lvl_r && !dt_dis_in) begin
            dead_r <= dtt_in;
         end else if (dead_r != '0) begin
            dead_r <= dead_r - 1'b1;
         end
      end
   end

   // Each side turns on only once the opposite edge has settled
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pulse_out <= 1'b0;
         hi_out    <= 1'b0;
         lo_out    <= 1'b0;
      end else begin
         pulse_out <= shot_r != '0;
         hi_out    <= lvl && settled;
         lo_out    <= !lvl && settled;
      end
   end
endmodule : pwm_phase
`default_nettype wire

// File: motor_pwm.sv
// Purpose: Three-phase motor PWM: carrier timer, duty timers, shutdown
// Assumes: Plain register port, read data one cycle after the strobe
// Notes:   Phase pins are driven only while enabled, else high-impedance
//
// Summary of operation
// - Transfer trigger: underflow plus request, or period write
// - Carrier timer underflow paces all phases
// - Mode 1 selects when new period applies
// - Underflow fires one-shot on every phase
// - Triangular mode 1 alternates primary and alternate duty
// - Guard floats all six phase pins when pair collides
// - Turn-on waits dead time after turn-off
// - Dead time on when disable is 0
// - Low interrupt pin floats duty timer outputs
// - Triangular modes 0, 1 and sawtooth modulation
// - Output enable clears on listed events
// - In use but disabled: six pins float
// - Interrupt after n, then every n underflows in triangular mode 1
`timescale 1ns/1ps
`default_nettype none
module motor_pwm (
   input  wire logic                          MCLK_IN,      // 10 MHz clock
   input  wire logic                          RST_N_IN,     // Sync reset
   input  wire logic [motor_pwm_pkg::AW-1:0]  ADDR_IN,      // Word address
   input  wire logic [motor_pwm_pkg::DW-1:0]  WDATA_IN,     // Write data
   input  wire logic                          WR_IN,        // Write strobe
   input  wire logic                          RD_IN,        // Read strobe
   input  wire logic                          NMI_N_IN,     // Shutdown pin
   output logic      [motor_pwm_pkg::DW-1:0]  RDATA_OUT,    // Read data
   output logic      [motor_pwm_pkg::NPH-1:0] PH_HI_OUT,    // High sides
   output logic      [motor_pwm_pkg::NPH-1:0] PH_HI_OE_OUT, // Drive enable
   output logic      [motor_pwm_pkg::NPH-1:0] PH_LO_OUT,    // Low sides
   output logic      [motor_pwm_pkg::NPH-1:0] PH_LO_OE_OUT, // Drive enable
   output logic      [motor_pwm_pkg::NPH-1:0] DUTY_OUT,     // Duty timers
   output logic      [motor_pwm_pkg::NPH-1:0] DUTY_OE_OUT,  // Drive enable
   output logic                               IRQ_OUT       // Interrupt
);
   localparam int DW  = motor_pwm_pkg::DW;
   localparam int NPH = motor_pwm_pkg::NPH;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   function automatic logic hit(input logic [motor_pwm_pkg::AW-1:0] a,
                                input logic [motor_pwm_pkg::AW-1:0] base);
      hit = (a == base);
   endfunction : hit

   logic wr_ctrl0;
   logic wr_ctrl1;
   logic wr_period;

   assign wr_ctrl0  = WR_IN && hit(ADDR_IN, motor_pwm_pkg::A_CTRL0);
   assign wr_ctrl1  = WR_IN && hit(ADDR_IN, motor_pwm_pkg::A_CTRL1);
   assign wr_period = WR_IN && hit(ADDR_IN, motor_pwm_pkg::A_PERIOD);

   ////////////////////////////////////////////////////////////////////////////
   // Control bits

   logic icnt_en_r;
   logic use_r;
   logic oen_r;
   logic guard_r;
   logic saw_r;
   logic mode1_r;
   logic dt_dis_r;
   logic cw_sel_r;
   logic chg_imm_r;
   logic nmi_en_r;
   logic trip;
   logic nmi_fall;

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         icnt_en_r <= 1'b0;
         use_r     <= 1'b0;
         guard_r   <= 1'b0;
         saw_r     <= 1'b0;
      end else if (wr_ctrl0) begin
         icnt_en_r <= WDATA_IN[motor_pwm_pkg::B_ICNT_EN];
         use_r     <= WDATA_IN[motor_pwm_pkg::B_USE];
         guard_r   <= WDATA_IN[motor_pwm_pkg::B_GUARD];
         saw_r     <= WDATA_IN[motor_pwm_pkg::B_MOD];
      end
   end

   // Hardware clears beat a software set in the same cycle
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         oen_r <= 1'b0;
      end else if ((trip && guard_r) || (nmi_fall && nmi_en_r)) begin
         oen_r <= 1'b0;
      end else if (wr_ctrl0) begin
         oen_r <= WDATA_IN[motor_pwm_pkg::B_OEN];
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         mode1_r   <= 1'b0;
         dt_dis_r  <= 1'b0;
         cw_sel_r  <= 1'b0;
         chg_imm_r <= 1'b0;
         nmi_en_r  <= 1'b0;
      end else if (wr_ctrl1) begin
         mode1_r   <= WDATA_IN[motor_pwm_pkg::B_MODE1];
         dt_dis_r  <= WDATA_IN[motor_pwm_pkg::B_DT_DIS];
         cw_sel_r  <= WDATA_IN[motor_pwm_pkg::B_CW_SEL];
         chg_imm_r <= WDATA_IN[motor_pwm_pkg::B_CHG_IMM];
         nmi_en_r  <= WDATA_IN[motor_pwm_pkg::B_NMI_EN];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Value registers

   logic [DW-1:0]                    period_r;
   logic [motor_pwm_pkg::DTW-1:0]    dtt_r;
   logic [motor_pwm_pkg::ICW-1:0]    icnt_r;
   logic [NPH-1:0][DW-1:0]           duty_r;
   logic [NPH-1:0][DW-1:0]           alt_r;

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         period_r <= motor_pwm_pkg::PERIOD_RST;
         dtt_r    <= motor_pwm_pkg::DTT_RST;
         icnt_r   <= motor_pwm_pkg::ICNT_RST;
      end else if (WR_IN) begin
         if (hit(ADDR_IN, motor_pwm_pkg::A_PERIOD)) begin
            period_r <= WDATA_IN;
         end
         if (hit(ADDR_IN, motor_pwm_pkg::A_DTT)) begin
            dtt_r <= WDATA_IN[motor_pwm_pkg::DTW-1:0];
         end
         if (hit(ADDR_IN, motor_pwm_pkg::A_ICNT)) begin
            icnt_r <= WDATA_IN[motor_pwm_pkg::ICW-1:0];
         end
      end
   end

   // Duty and alternate registers for U, V, W
   generate
      for (genvar i = 0; i < NPH; i++) begin : g_duty
         always_ff @(posedge MCLK_IN) begin
            if (!RST_N_IN) begin
               duty_r[i] <= '0;
               alt_r[i]  <= '0;
            end else if (WR_IN) begin
               if (hit(ADDR_IN, motor_pwm_pkg::A_DUTY0 + 4'(i))) begin
                  duty_r[i] <= WDATA_IN;
               end
               if (hit(ADDR_IN, motor_pwm_pkg::A_ALT0 + 4'(i))) begin
                  alt_r[i] <= WDATA_IN;
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Carrier timer

   logic [DW-1:0] cnt_r;
   logic [DW-1:0] act_period_r;
   logic          uflow;

   assign uflow = use_r && (cnt_r == '0);

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         cnt_r <= motor_pwm_pkg::PERIOD_RST;
      end else if (!use_r) begin
         cnt_r <= act_period_r;
      end else if (uflow) begin
         cnt_r <= act_period_r;
      end else begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   // Mode 0 always takes a new period at underflow
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         act_period_r <= motor_pwm_pkg::PERIOD_RST;
      end else if (wr_period && mode1_r && chg_imm_r) begin
         act_period_r <= WDATA_IN;
      end else if (uflow || !use_r) begin
         act_period_r <= period_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transfer trigger and working duty copies

   logic                 xfer_req_r;
   logic                 xfer;
   logic [NPH-1:0][DW-1:0] wduty_r;
   logic [NPH-1:0][DW-1:0] walt_r;

   assign xfer = (uflow && xfer_req_r) || (wr_period && cw_sel_r);

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         xfer_req_r <= 1'b0;
      end else if (wr_ctrl0 && WDATA_IN[motor_pwm_pkg::B_XFER]) begin
         xfer_req_r <= 1'b1;
      end else if (uflow) begin
         xfer_req_r <= 1'b0;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         wduty_r <= '0;
         walt_r  <= '0;
      end else if (xfer) begin
         wduty_r <= duty_r;
         walt_r  <= alt_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Half-cycle tracking: mode 1 source swap, triangular polarity

   logic alt_sel_r;
   logic half_r;

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN || !use_r) begin
         alt_sel_r <= 1'b0;
         half_r    <= 1'b0;
      end else if (uflow) begin
         alt_sel_r <= mode1_r && !saw_r && !alt_sel_r;
         half_r    <= !saw_r && !half_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Phases

   logic [NPH-1:0] pulse;
   logic [NPH-1:0] hi;
   logic [NPH-1:0] lo;

   generate
      for (genvar i = 0; i < NPH; i++) begin : g_ph
         pwm_phase u_phase (
            .clk_in    (MCLK_IN),
            .rst_n_in  (RST_N_IN),
            .trig_in   (uflow),
            .load_in   (alt_sel_r ? walt_r[i] : wduty_r[i]),
            .inv_in    (half_r),
            .dt_dis_in (dt_dis_r),
            .dtt_in    (dtt_r),
            .pulse_out (pulse[i]),
            .hi_out    (hi[i]),
            .lo_out    (lo[i])
         );
      end
   endgenerate

   assign trip = use_r && oen_r && |(hi & lo);

   ////////////////////////////////////////////////////////////////////////////
   // Shutdown pin synchroniser

   logic nmi_m_r;
   logic nmi_s_r;
   logic nmi_d_r;

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         nmi_m_r <= 1'b1;
         nmi_s_r <= 1'b1;
         nmi_d_r <= 1'b1;
      end else begin
         nmi_m_r <= NMI_N_IN;
         nmi_s_r <= nmi_m_r;
         nmi_d_r <= nmi_s_r;
      end
   end

   assign nmi_fall = nmi_d_r && !nmi_s_r;

   ////////////////////////////////////////////////////////////////////////////
   // Carrier interrupt thinning

   logic [motor_pwm_pkg::ICW-1:0] ictr_r;
   logic                          cirq;

   // Counting applies only to triangular mode 1; else every underflow
   assign cirq = uflow && (!(icnt_en_r && mode1_r && !saw_r) ||
                           ictr_r >= icnt_r);

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN || !icnt_en_r) begin
         ictr_r <= motor_pwm_pkg::ICNT_START;
      end else if (uflow) begin
         ictr_r <= cirq ? motor_pwm_pkg::ICNT_START : ictr_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status, enable, clear

   logic [motor_pwm_pkg::NIRQ-1:0] ist_r;
   logic [motor_pwm_pkg::NIRQ-1:0] ien_r;
   logic [motor_pwm_pkg::NIRQ-1:0] iset;
   logic [motor_pwm_pkg::NIRQ-1:0] iclr;

   always_comb begin
      iset = '0;
      iset[motor_pwm_pkg::I_CARRIER] = cirq;
      iset[motor_pwm_pkg::I_GUARD]   = trip && guard_r;
      iset[motor_pwm_pkg::I_NMI]     = nmi_fall && nmi_en_r;
   end

   assign iclr = (WR_IN && hit(ADDR_IN, motor_pwm_pkg::A_IRQ_CLR)) ?
                 WDATA_IN[motor_pwm_pkg::NIRQ-1:0] : '0;

   // A new event wins over a clear in the same cycle
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         ist_r <= '0;
      end else begin
         ist_r <= (ist_r & ~iclr) | iset;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         ien_r <= '0;
      end else if (WR_IN && hit(ADDR_IN, motor_pwm_pkg::A_IRQ_EN)) begin
         ien_r <= WDATA_IN[motor_pwm_pkg::NIRQ-1:0];
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         IRQ_OUT <= 1'b0;
      end else begin
         IRQ_OUT <= |(((ist_r & ~iclr) | iset) & ien_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pins

   logic drive;

   assign drive = use_r && oen_r && !(trip && guard_r);

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         PH_HI_OUT    <= '0;
         PH_LO_OUT    <= '0;
         PH_HI_OE_OUT <= '0;
         PH_LO_OE_OUT <= '0;
      end else begin
         PH_HI_OUT    <= hi;
         PH_LO_OUT    <= lo;
         PH_HI_OE_OUT <= {NPH{drive}};
         PH_LO_OE_OUT <= {NPH{drive}};
      end
   end

   // Floats while the pin is low, even after enable has dropped
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         DUTY_OUT    <= '0;
         DUTY_OE_OUT <= '0;
      end else begin
         DUTY_OUT    <= pulse;
         DUTY_OE_OUT <= {NPH{use_r && !(nmi_en_r && !nmi_s_r)}};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port

   logic [DW-1:0] rmux;

   always_comb begin
      rmux = '0;
      unique case (ADDR_IN)
         motor_pwm_pkg::A_CTRL0: begin
            rmux[motor_pwm_pkg::B_ICNT_EN] = icnt_en_r;
            rmux[motor_pwm_pkg::B_USE]     = use_r;
            rmux[motor_pwm_pkg::B_OEN]     = oen_r;
            rmux[motor_pwm_pkg::B_GUARD]   = guard_r;
            rmux[motor_pwm_pkg::B_MOD]     = saw_r;
         end
         motor_pwm_pkg::A_CTRL1: begin
            rmux[motor_pwm_pkg::B_MODE1]   = mode1_r;
            rmux[motor_pwm_pkg::B_DT_DIS]  = dt_dis_r;
            rmux[motor_pwm_pkg::B_CW_SEL]  = cw_sel_r;
            rmux[motor_pwm_pkg::B_CHG_IMM] = chg_imm_r;
            rmux[motor_pwm_pkg::B_NMI_EN]  = nmi_en_r;
         end
         motor_pwm_pkg::A_PERIOD:   rmux = period_r;
         motor_pwm_pkg::A_DTT:      rmux[motor_pwm_pkg::DTW-1:0] = dtt_r;
         motor_pwm_pkg::A_ICNT:     rmux[motor_pwm_pkg::ICW-1:0] = icnt_r;
         4'h5, 4'h6, 4'h7:
            rmux = duty_r[2'(ADDR_IN - motor_pwm_pkg::A_DUTY0)];
         4'h8, 4'h9, 4'ha:
            rmux = alt_r[2'(ADDR_IN - motor_pwm_pkg::A_ALT0)];
         motor_pwm_pkg::A_CNT:      rmux = cnt_r;
         motor_pwm_pkg::A_IRQ_STAT: rmux[motor_pwm_pkg::NIRQ-1:0] = ist_r;
         motor_pwm_pkg::A_IRQ_EN:   rmux[motor_pwm_pkg::NIRQ-1:0] = ien_r;
         motor_pwm_pkg::A_IRQ_CLR:  rmux = '0;
         motor_pwm_pkg::A_STATUS: begin
            rmux[0] = alt_sel_r;
            rmux[1] = xfer_req_r;
            rmux[2] = !nmi_s_r;
         end
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         RDATA_OUT <= '0;
      end else begin
         RDATA_OUT <= RD_IN ? rmux : '0;
      end
   end
endmodule : motor_pwm
`default_nettype wire

// File: motor_pwm_assertions.sv
// Purpose: Port-level checks for the three-phase PWM block
// Assumes: Software bits are mirrored from register port writes
// Notes:   Mirrors miss hardware clears, so oen_r gates only the "off" check
`timescale 1ns/1ps
`default_nettype none
module motor_pwm_assertions (
   input wire logic        MCLK_IN,      // Clock
   input wire logic        RST_N_IN,     // Sync reset
   input wire logic [3:0]  ADDR_IN,      // Address
   input wire logic [15:0] WDATA_IN,     // Write data
   input wire logic        WR_IN,        // Write strobe
   input wire logic        NMI_N_IN,     // Shutdown pin
   input wire logic [2:0]  PH_HI_OUT,    // High sides
   input wire logic [2:0]  PH_HI_OE_OUT, // High enables
   input wire logic [2:0]  PH_LO_OUT,    // Low sides
   input wire logic [2:0]  PH_LO_OE_OUT, // Low enables
   input wire logic [2:0]  DUTY_OE_OUT,  // Duty enables
   input wire logic        IRQ_OUT       // Interrupt
);
   logic       use_r, oen_r, dtdis_r, nmi_en_r;
   logic [2:0] ien_r;
   logic [7:0] dtt_r;
   wire logic  live = use_r && oen_r;

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         {oen_r, use_r} <= 2'h0;
         {nmi_en_r, dtdis_r} <= 2'h0;
         ien_r <= 3'h0;
         dtt_r <= 8'h00;
      end else if (WR_IN) begin
         case (ADDR_IN)
            motor_pwm_pkg::A_CTRL0:  {oen_r, use_r} <= WDATA_IN[3:2];
            motor_pwm_pkg::A_CTRL1:  {nmi_en_r, dtdis_r} <= {WDATA_IN[4], WDATA_IN[1]};
            motor_pwm_pkg::A_DTT:    dtt_r <= WDATA_IN[7:0];
            motor_pwm_pkg::A_IRQ_EN: ien_r <= WDATA_IN[2:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!RST_N_IN);
   sequence nmi_held_s;
      (nmi_en_r && !NMI_N_IN) [*4];
   endsequence
   sequence lo_off_s;
      !dtdis_r && dtt_r > 8'h01 && $fell(PH_LO_OUT[0]);
   endsequence

   pair_oe_a: assert property (PH_HI_OE_OUT == PH_LO_OE_OUT)
      else $error("pair enables differ");
   no_shoot_a: assert property ((PH_HI_OUT & PH_LO_OUT) == 3'h0)
      else $error("both sides of a pair on");
   oe_off_a: assert property (!live && !$past(live) |-> (PH_HI_OE_OUT | PH_LO_OE_OUT) == 3'h0)
      else $error("pins driven while disabled");
   nmi_float_a: assert property (nmi_held_s |-> DUTY_OE_OUT == 3'h0)
      else $error("duty pins driven during shutdown");
   irq_quiet_a: assert property (ien_r == 3'h0 && $past(ien_r) == 3'h0 |-> !IRQ_OUT)
      else $error("interrupt while all masked");
   comp_pair_a: assert property (use_r && dtdis_r && $past(use_r, 2) && $past(dtdis_r, 2)
      |-> PH_HI_OUT == ~PH_LO_OUT)
      else $error("pair not complementary");
   dead_gap_a: assert property (lo_off_s |-> !PH_HI_OUT[0] [*2])
      else $error("turn-on without dead time");
   carrier_irq_a: assert property ($rose(ien_r[0]) && use_r |-> ##[0:600] IRQ_OUT)
      else $error("no carrier interrupt");
endmodule : motor_pwm_assertions

bind motor_pwm motor_pwm_assertions chk (.MCLK_IN, .RST_N_IN, .ADDR_IN, .WDATA_IN, .WR_IN,
   .NMI_N_IN, .PH_HI_OUT, .PH_HI_OE_OUT, .PH_LO_OUT, .PH_LO_OE_OUT, .DUTY_OE_OUT, .IRQ_OUT);
`default_nettype wire

// File: gate_driver_model.sv
// Purpose: Gate driver stand-in on the far side of the phase pins
// Assumes: Released gate inputs are pulled down inside the driver
// Notes:   Counts cycles with both gates of one pair on
`timescale 1ns/1ps
`default_nettype none
module gate_driver_model (
   input  wire logic       clk_in,      // Clock
   input  wire logic [2:0] hi_in,       // High levels
   input  wire logic [2:0] hi_oe_in,    // High enables
   input  wire logic [2:0] lo_in,       // Low levels
   input  wire logic [2:0] lo_oe_in,    // Low enables
   output var  int         shoot_out    // Shoot-through cycles
);
   // A floating pin reads as off, so a float never counts as a collision
   wire logic [2:0] gate_hi = hi_in & hi_oe_in;
   wire logic [2:0] gate_lo = lo_in & lo_oe_in;
   // Two-state count starts at zero, so this process is its only driver
   always @(posedge clk_in) begin
      if (|(gate_hi & gate_lo)) shoot_out <= shoot_out + 1;
   end
endmodule : gate_driver_model
`default_nettype wire

// File: tb_three_phase_motor_pwm.sv
// Purpose: Self-checking bench for the three-phase PWM block
// Assumes: Carrier period 0x13, so one carrier is 20 cycles
// Notes:   Model keeps software-visible register bits only
`timescale 1ns/1ps
`default_nettype none
module tb_three_phase_motor_pwm;
   logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, nmi_n = 1'b1, irq;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000, rdata, v;
   logic [2:0]  hi, hi_oe, lo, lo_oe, duty, duty_oe;
   int          failures = 0, n_compared = 0, shoots, seed = 32'h3c373943, h1, h2;
   time         t0;
   logic [15:0] regs [11] = '{16'h0, 16'h0, 16'hff, 16'h0, 16'h1, 16'h0, 16'h0, 16'h0,
                               16'h0, 16'h0, 16'h0};
   logic [15:0] msk [11] = '{16'h5d, 16'h1f, 16'hffff, 16'hff, 16'hf, 16'hffff, 16'hffff,
                              16'hffff, 16'hffff, 16'hffff, 16'hffff};
   wire logic [9:0] obs = {irq, lo, hi, duty};

   always #50 clk = ~clk;
   motor_pwm dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
      .WR_IN(wr), .RD_IN(rd), .NMI_N_IN(nmi_n), .RDATA_OUT(rdata), .PH_HI_OUT(hi),
      .PH_HI_OE_OUT(hi_oe), .PH_LO_OUT(lo), .PH_LO_OE_OUT(lo_oe), .DUTY_OUT(duty),
      .DUTY_OE_OUT(duty_oe), .IRQ_OUT(irq));
   gate_driver_model gdm (.clk_in(clk), .hi_in(hi), .hi_oe_in(hi_oe), .lo_in(lo),
      .lo_oe_in(lo_oe), .shoot_out(shoots));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict();
      if (failures == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      if (a < 4'hb) regs[a] = d & msk[a];
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg
   // Bounded wait, sampled 1 ns after the edge so outputs have settled
   task automatic wait_pin(input int b, input logic lvl);
      int k;
      #1;
      for (k = 0; k < 3000 && obs[b] !== lvl; k++) begin
         @(posedge clk);
         #1;
      end
      if (k == 3000) chk(16'h1, 16'h0);
   endtask : wait_pin
   task automatic hi_len(input int b, output int len);
      wait_pin(b, 1'b0);
      wait_pin(b, 1'b1);
      t0 = $time;
      wait_pin(b, 1'b0);
      len = int'(($time - t0) / 100);
   endtask : hi_len

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         rd_reg(4'(i));
         chk(v, regs[i]);
      end
      for (int i = 2; i < 11; i++) wr_reg(4'(i), 16'($random(seed)));
      for (int i = 2; i < 11; i++) begin
         rd_reg(4'(i));
         chk(v, regs[i]);
      end
      rd_reg(4'he);
      chk(v, 16'h0);
      wr_reg(4'h2, 16'h13);
      wr_reg(4'h1, 16'h2);
      for (int i = 5; i < 8; i++) wr_reg(4'(i), 16'h6 + 16'($unsigned($random(seed)) % 8));
      wr_reg(4'h0, 16'h9c);
      repeat (2) hi_len(0, h1);
      for (int i = 0; i < 3; i++) begin
         hi_len(i, h1);
         chk(16'(h1), regs[5 + i]);
      end
      wait_pin(0, 1'b0);
      wait_pin(0, 1'b1);
      chk(16'(duty), 16'h7);
      chk(16'({hi_oe, lo_oe, duty_oe}), 16'h1ff);
      chk(16'(hi ^ lo), 16'h7);
      t0 = $time;
      wait_pin(0, 1'b0);
      wait_pin(0, 1'b1);
      chk(16'(($time - t0) / 100), 16'h14);
      wr_reg(4'h3, 16'h4);
      wr_reg(4'h1, 16'h0);
      wait_pin(6, 1'b1);
      wait_pin(6, 1'b0);
      t0 = $time;
      wait_pin(3, 1'b1);
      h1 = int'(($time - t0) / 100);
      chk(16'(h1 >= 4 && h1 <= 6), 16'h1);
      do rd_reg(4'hb); while (v < 16'ha);
      for (int i = 0; i < 3; i++) wr_reg(4'(8 + i), 16'h13 - regs[5 + i]);
      wr_reg(4'h4, 16'h3);
      wr_reg(4'h1, 16'h3);
      wr_reg(4'h0, 16'h8d);
      wr_reg(4'hd, 16'h1);
      repeat (2) hi_len(0, h1);
      hi_len(0, h2);
      chk(16'(h1 + h2), 16'h13);
      chk(16'(h1 == regs[5] || h2 == regs[5]), 16'h1);
      wait_pin(9, 1'b1);
      rd_reg(4'hc);
      chk(v & 16'h1, 16'h1);
      wr_reg(4'he, 16'h1);
      #1 chk(16'(irq), 16'h0);
      wait_pin(9, 1'b1);
      t0 = $time;
      wr_reg(4'he, 16'h1);
      wait_pin(9, 1'b1);
      chk(16'(($time - t0) / 100), 16'h3c);
      wr_reg(4'hd, 16'h0);
      repeat (70) @(posedge clk);
      rd_reg(4'hc);
      chk(16'({v[0], irq}), 16'h2);
      wr_reg(4'h1, 16'h13);
      nmi_n <= 1'b0;
      repeat (5) @(posedge clk);
      #1 chk(16'({duty_oe, hi_oe, lo_oe}), 16'h0);
      rd_reg(4'h0);
      chk(v, regs[0] & 16'hfff7);
      rd_reg(4'hc);
      chk(v & 16'h4, 16'h4);
      @(posedge clk);
      nmi_n <= 1'b1;
      wr_reg(4'h1, 16'h6);
      wr_reg(4'h0, 16'h4c);
      wr_reg(4'h5, 16'h3);
      wr_reg(4'h2, 16'h13);
      repeat (3) hi_len(3, h1);
      chk(16'(h1), 16'h3);
      chk(16'(shoots), 16'h0);
      give_verdict();
   end

   initial begin
      #2000000;
      failures++;
      give_verdict();
   end
endmodule : tb_three_phase_motor_pwm
`default_nettype wire
